// ===== core/cc_map.vh
// Register map, field positions, reset values and mode codes of the
// capture/compare channel. Definitions only; included by bare name.
`ifndef CC_MAP_VH
`define CC_MAP_VH

// Register byte offsets (APB, one 32-bit word each)
`define CC_OFF_CAP_CTRL    12'h000
`define CC_OFF_CAP_BUF     12'h004
`define CC_OFF_CMP_CTRL    12'h008
`define CC_OFF_CMP_PRI     12'h00C
`define CC_OFF_CMP_SEC     12'h010

// Capture control fields
`define CC_CAP_IDLE_BIT    13
`define CC_CAP_TSEL_BIT    7
`define CC_CAP_CPI_HI      6
`define CC_CAP_CPI_LO      5
`define CC_CAP_OVF_BIT     4
`define CC_CAP_BNE_BIT     3
`define CC_CAP_MODE_HI     2
`define CC_CAP_MODE_LO     0

// Compare control fields
`define CC_CMP_IDLE_BIT    13
`define CC_CMP_FLT_BIT     4
`define CC_CMP_TSEL_BIT    3
`define CC_CMP_MODE_HI     2
`define CC_CMP_MODE_LO     0

// Reset values
`define CC_RST_MODE        3'h0
`define CC_RST_CPI         2'h0
`define CC_RST_VALUE       16'h0000

// Capture modes
`define CC_CAP_OFF         3'h0
`define CC_CAP_EVERY       3'h1
`define CC_CAP_FALL        3'h2
`define CC_CAP_RISE        3'h3
`define CC_CAP_RISE4       3'h4
`define CC_CAP_RISE16      3'h5
`define CC_CAP_UNUSED      3'h6
`define CC_CAP_WAKE        3'h7

// Prescaler terminal counts
`define CC_PRE4_LAST       4'h3
`define CC_PRE16_LAST      4'hF

// Compare modes
`define CC_CMP_OFF         3'h0
`define CC_CMP_HIGH_SHOT   3'h1
`define CC_CMP_LOW_SHOT    3'h2
`define CC_CMP_TOGGLE      3'h3
`define CC_CMP_DLY_SHOT    3'h4
`define CC_CMP_CONT        3'h5
`define CC_CMP_PWM         3'h6
`define CC_CMP_PWM_FLT     3'h7

`endif

// ===== core/pin_sync3.v
// Three-stage synchroniser for one asynchronous pin with agreement filter.
// Assumes the pin is unrelated to ref_clk_i; output moves only when the
// second and third stages agree.
`timescale 1ns/1ps
`default_nettype none

module pin_sync3 #(
  parameter INIT = 1'b0
) (
  // Clock and reset
  input  wire ref_clk_i,
  input  wire rstn_i,
  // Pin and filtered level
  input  wire pin_i,
  output reg  level_o
);

  reg s1_r;
  reg s2_r;
  reg s3_r;

  // First stage feeds only the second stage
  always @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      s1_r    <= INIT;
      s2_r    <= INIT;
      s3_r    <= INIT;
      level_o <= INIT;
    end else begin
      s1_r <= pin_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        level_o <= s3_r;
      end
    end
  end

endmodule // pin_sync3

`default_nettype wire

// ===== core/timer_capture_compare_channel.v
// One input capture channel and one output compare channel on APB.
// Assumes both time base timers are counted outside and arrive on the
// system clock; idle and sleep come from the power controller, same clock.
`timescale 1ns/1ps
`default_nettype none
`include "cc_map.vh"

module timer_capture_compare_channel #(
  parameter DEPTH_LOG2 = 2
) (
  // Clock and reset
  input  wire        ref_clk_i,
  input  wire        rstn_i,
  // APB slave
  input  wire [11:0] paddr_i,
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [31:0] pwdata_i,
  output reg  [31:0] prdata_o,
  output reg         pready_o,
  output reg         pslverr_o,
  // Time bases and power state
  input  wire [15:0] second_timer_count_i,
  input  wire [15:0] third_timer_count_i,
  input  wire        cpu_idle_i,
  input  wire        cpu_sleep_i,
  // Pins
  input  wire        capture_input_pin_i,
  input  wire        compare_fault_input_i,
  output reg         compare_output_pin_o,
  output reg         compare_output_oe_o,
  // Events
  output reg         capture_irq_o,
  output reg         compare_irq_o,
  output reg         wake_o
);

  localparam DEPTH = 1 << DEPTH_LOG2;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  wire cap_lvl;
  wire flt_lvl;

  pin_sync3 #(.INIT(1'b0)) u_cap_sync (
    .ref_clk_i (ref_clk_i),
    .rstn_i    (rstn_i),
    .pin_i     (capture_input_pin_i),
    .level_o   (cap_lvl)
  );

  // Fault idles high so reset does not look like a falling edge
  pin_sync3 #(.INIT(1'b1)) u_flt_sync (
    .ref_clk_i (ref_clk_i),
    .rstn_i    (rstn_i),
    .pin_i     (compare_fault_input_i),
    .level_o   (flt_lvl)
  );

  ////////////////////////////////////////////////////////////////////////
  // APB decode

  wire acc_start = psel_i & penable_i & ~pready_o;
  wire acc_done  = psel_i & penable_i & pready_o;
  wire wr_done   = acc_done & pwrite_i;
  wire rd_done   = acc_done & ~pwrite_i;

  wire sel_cap_ctrl = (paddr_i == `CC_OFF_CAP_CTRL);
  wire sel_cap_buf  = (paddr_i == `CC_OFF_CAP_BUF);
  wire sel_cmp_ctrl = (paddr_i == `CC_OFF_CMP_CTRL);
  wire sel_cmp_pri  = (paddr_i == `CC_OFF_CMP_PRI);
  wire sel_cmp_sec  = (paddr_i == `CC_OFF_CMP_SEC);
  wire sel_any      = sel_cap_ctrl | sel_cap_buf | sel_cmp_ctrl |
                      sel_cmp_pri | sel_cmp_sec;

  wire low_power = cpu_idle_i | cpu_sleep_i;

  ////////////////////////////////////////////////////////////////////////
  // Capture state

  reg        cap_stop_r;
  reg        cap_tsel_r;
  reg  [1:0] cap_cpi_r;
  reg  [2:0] cap_mode_r;
  reg        cap_ovf_r;
  reg        cap_prev_r;
  reg  [3:0] cap_pre_r;
  reg  [1:0] cap_icnt_r;
  reg  [DEPTH_LOG2-1:0] wr_ptr_r;
  reg  [DEPTH_LOG2-1:0] rd_ptr_r;
  reg  [DEPTH_LOG2:0]   fill_r;
  reg  [15:0] buf_mem [0:DEPTH-1];

  wire cap_ctrl_wr = wr_done & sel_cap_ctrl;
  wire cap_rise    = cap_lvl & ~cap_prev_r;
  wire cap_fall    = ~cap_lvl & cap_prev_r;
  wire cap_run     = ~(cpu_idle_i & cap_stop_r);
  // Fill never passes DEPTH, so its top bit alone marks a full buffer
  wire buf_full    = fill_r[DEPTH_LOG2];
  wire buf_nempty  = (fill_r != {(DEPTH_LOG2+1){1'b0}});
  wire [15:0] cap_time = cap_tsel_r ? second_timer_count_i :
                                      third_timer_count_i;

  reg cap_ev_raw;
  always @* begin
    case (cap_mode_r)
      `CC_CAP_EVERY:  cap_ev_raw = cap_rise | cap_fall;
      `CC_CAP_FALL:   cap_ev_raw = cap_fall;
      `CC_CAP_RISE:   cap_ev_raw = cap_rise;
      `CC_CAP_RISE4:  cap_ev_raw = cap_rise & (cap_pre_r == `CC_PRE4_LAST);
      `CC_CAP_RISE16: cap_ev_raw = cap_rise & (cap_pre_r == `CC_PRE16_LAST);
      default:        cap_ev_raw = 1'b0;
    endcase
  end

  wire cap_ev   = cap_ev_raw & cap_run;
  wire cap_push = cap_ev & ~buf_full;
  wire cap_pop  = rd_done & sel_cap_buf & buf_nempty;

  // Interrupt after the selected number of captures; mode 001 interrupts on every capture
  wire cap_cnt_hit = (cap_mode_r == `CC_CAP_EVERY) |
                     (cap_icnt_r == cap_cpi_r);
  // Mode 111 ignores all other capture settings
  wire cap_wake_ev = (cap_mode_r == `CC_CAP_WAKE) & cap_rise &
                     low_power;

  // Buffer storage has no reset; only entries below fill are visible
  always @(posedge ref_clk_i) begin
    if (cap_push) begin
      buf_mem[wr_ptr_r] <= cap_time;
    end
  end

  always @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      cap_stop_r <= 1'b0;
      cap_tsel_r <= 1'b0;
      cap_cpi_r  <= `CC_RST_CPI;
      cap_mode_r <= `CC_RST_MODE;
      cap_ovf_r  <= 1'b0;
      cap_prev_r <= 1'b0;
      cap_pre_r  <= 4'h0;
      cap_icnt_r <= 2'h0;
      wr_ptr_r   <= {DEPTH_LOG2{1'b0}};
      rd_ptr_r   <= {DEPTH_LOG2{1'b0}};
      fill_r     <= {(DEPTH_LOG2+1){1'b0}};
    end else begin
      cap_prev_r <= cap_lvl;
      if (cap_ctrl_wr) begin
        cap_stop_r <= pwdata_i[`CC_CAP_IDLE_BIT];
        cap_tsel_r <= pwdata_i[`CC_CAP_TSEL_BIT];
        cap_cpi_r  <= pwdata_i[`CC_CAP_CPI_HI:`CC_CAP_CPI_LO];
        cap_mode_r <= pwdata_i[`CC_CAP_MODE_HI:`CC_CAP_MODE_LO];
        cap_pre_r  <= 4'h0;
        cap_icnt_r <= 2'h0;
      end else begin
        if (cap_rise & cap_run & ((cap_mode_r == `CC_CAP_RISE4) |
                                  (cap_mode_r == `CC_CAP_RISE16))) begin
          cap_pre_r <= (cap_ev_raw) ? 4'h0 : cap_pre_r + 4'h1;
        end
        if (cap_ev) begin
          cap_icnt_r <= cap_cnt_hit ? 2'h0 : cap_icnt_r + 2'h1;
        end
      end
      // Overflow only clears when the channel is switched off
      if (cap_ev & buf_full) begin
        cap_ovf_r <= 1'b1;
      end else if (cap_mode_r == `CC_CAP_OFF) begin
        cap_ovf_r <= 1'b0;
      end
      if (cap_push) begin
        wr_ptr_r <= wr_ptr_r + {{(DEPTH_LOG2-1){1'b0}}, 1'b1};
      end
      if (cap_pop) begin
        rd_ptr_r <= rd_ptr_r + {{(DEPTH_LOG2-1){1'b0}}, 1'b1};
      end
      if (cap_push & ~cap_pop) begin
        fill_r <= fill_r + {{DEPTH_LOG2{1'b0}}, 1'b1};
      end else if (cap_pop & ~cap_push) begin
        fill_r <= fill_r - {{DEPTH_LOG2{1'b0}}, 1'b1};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Compare state

  reg        cmp_stop_r;
  reg        cmp_tsel_r;
  reg  [2:0] cmp_mode_r;
  reg        cmp_flt_r;
  reg        cmp_done_r;
  reg [15:0] cmp_pri_r;
  reg [15:0] cmp_sec_r;
  reg        mp_prev_r;
  reg        ms_prev_r;
  reg        zero_prev_r;
  reg        flt_prev_r;

  wire cmp_ctrl_wr = wr_done & sel_cmp_ctrl;
  wire [2:0] new_mode = pwdata_i[`CC_CMP_MODE_HI:`CC_CMP_MODE_LO];
  wire [15:0] cmp_time = cmp_tsel_r ? third_timer_count_i :
                                      second_timer_count_i;
  wire cmp_run  = ~(cpu_idle_i & cmp_stop_r);
  wire match_p  = (cmp_time == cmp_pri_r);
  wire match_s  = (cmp_time == cmp_sec_r);
  wire at_zero  = (cmp_time == 16'h0000);
  // Edge of a match so a slow, prescaled timer fires once per value
  wire hit_p    = match_p & ~mp_prev_r & cmp_run;
  wire hit_s    = match_s & ~ms_prev_r & cmp_run;
  wire hit_zero = at_zero & ~zero_prev_r & cmp_run;
  wire flt_fall = ~flt_lvl & flt_prev_r;
  wire is_pwm   = (cmp_mode_r == `CC_CMP_PWM) |
                  (cmp_mode_r == `CC_CMP_PWM_FLT);

  reg        out_nxt;
  reg        done_nxt;
  reg        flt_nxt;
  reg        cirq_nxt;

  always @* begin
    out_nxt  = compare_output_pin_o;
    done_nxt = cmp_done_r;
    flt_nxt  = cmp_flt_r;
    cirq_nxt = 1'b0;
    if (cmp_ctrl_wr) begin
      done_nxt = 1'b0;
      // A fault edge in the write cycle wins over the clear
      if (flt_fall & (new_mode == `CC_CMP_PWM_FLT)) begin
        flt_nxt  = 1'b1;
        cirq_nxt = 1'b1;
      end else if (flt_lvl) begin
        flt_nxt = 1'b0;
      end
      case (new_mode)
        `CC_CMP_HIGH_SHOT: out_nxt = 1'b0;
        `CC_CMP_LOW_SHOT:  out_nxt = 1'b1;
        `CC_CMP_TOGGLE:    out_nxt = compare_output_pin_o;
        `CC_CMP_DLY_SHOT:  out_nxt = 1'b0;
        `CC_CMP_CONT:      out_nxt = 1'b0;
        `CC_CMP_PWM:       out_nxt = (cmp_pri_r != 16'h0000);
        `CC_CMP_PWM_FLT:   out_nxt = (cmp_pri_r != 16'h0000) &
                                     ~(flt_nxt);
        default:           out_nxt = 1'b0;
      endcase
    end else begin
      case (cmp_mode_r)
        `CC_CMP_HIGH_SHOT: begin
          if (hit_p) begin
            out_nxt = 1'b1;
          end
          cirq_nxt = out_nxt & ~compare_output_pin_o;
        end
        `CC_CMP_LOW_SHOT: begin
          if (hit_p) begin
            out_nxt = 1'b0;
          end
          cirq_nxt = ~out_nxt & compare_output_pin_o;
        end
        `CC_CMP_TOGGLE: begin
          if (hit_p) begin
            out_nxt = ~compare_output_pin_o;
          end
          cirq_nxt = hit_p;
        end
        `CC_CMP_DLY_SHOT, `CC_CMP_CONT: begin
          if (~cmp_done_r & hit_p) begin
            out_nxt = 1'b1;
          end else if (~cmp_done_r & hit_s & compare_output_pin_o) begin
            out_nxt  = 1'b0;
            done_nxt = (cmp_mode_r == `CC_CMP_DLY_SHOT);
          end
          cirq_nxt = ~out_nxt & compare_output_pin_o;
        end
        `CC_CMP_PWM: begin
          if (hit_zero) begin
            out_nxt = (cmp_sec_r != 16'h0000);
          end else if (hit_p) begin
            out_nxt = 1'b0;
          end
          cirq_nxt = 1'b0;
        end
        `CC_CMP_PWM_FLT: begin
          if (cmp_flt_r | flt_fall) begin
            out_nxt = 1'b0;
            flt_nxt = 1'b1;
          end else if (hit_zero) begin
            out_nxt = (cmp_sec_r != 16'h0000);
          end else if (hit_p) begin
            out_nxt = 1'b0;
          end
          cirq_nxt = flt_fall & ~cmp_flt_r;
        end
        default: begin
          out_nxt = 1'b0;
        end
      endcase
    end
  end

  always @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      cmp_stop_r  <= 1'b0;
      cmp_tsel_r  <= 1'b0;
      cmp_mode_r  <= `CC_RST_MODE;
      cmp_flt_r   <= 1'b0;
      cmp_done_r  <= 1'b0;
      cmp_pri_r   <= `CC_RST_VALUE;
      cmp_sec_r   <= `CC_RST_VALUE;
      mp_prev_r   <= 1'b0;
      ms_prev_r   <= 1'b0;
      zero_prev_r <= 1'b0;
      flt_prev_r  <= 1'b1;
      compare_output_pin_o <= 1'b0;
      compare_output_oe_o  <= 1'b0;
      compare_irq_o        <= 1'b0;
    end else begin
      flt_prev_r <= flt_lvl;
      if (cmp_run) begin
        mp_prev_r   <= match_p;
        ms_prev_r   <= match_s;
        zero_prev_r <= at_zero;
      end
      if (cmp_ctrl_wr) begin
        cmp_stop_r <= pwdata_i[`CC_CMP_IDLE_BIT];
        cmp_tsel_r <= pwdata_i[`CC_CMP_TSEL_BIT];
        cmp_mode_r <= new_mode;
      end
      // Period start reloads the duty so a running PWM never glitches
      if (wr_done & sel_cmp_pri) begin
        cmp_pri_r <= pwdata_i[15:0];
      end else if (is_pwm & hit_zero) begin
        cmp_pri_r <= cmp_sec_r;
      end
      if (wr_done & sel_cmp_sec) begin
        cmp_sec_r <= pwdata_i[15:0];
      end
      cmp_flt_r            <= flt_nxt;
      cmp_done_r           <= done_nxt;
      compare_output_pin_o <= out_nxt;
      compare_output_oe_o  <= cmp_ctrl_wr ? (new_mode != `CC_CMP_OFF) :
                              (cmp_mode_r != `CC_CMP_OFF);
      compare_irq_o        <= cirq_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Events and APB answer

  reg [31:0] rdata;
  always @* begin
    rdata = 32'h0000_0000;
    if (sel_cap_ctrl) begin
      rdata[`CC_CAP_IDLE_BIT] = cap_stop_r;
      rdata[`CC_CAP_TSEL_BIT] = cap_tsel_r;
      rdata[`CC_CAP_CPI_HI:`CC_CAP_CPI_LO] = cap_cpi_r;
      rdata[`CC_CAP_OVF_BIT]  = cap_ovf_r;
      rdata[`CC_CAP_BNE_BIT]  = buf_nempty;
      rdata[`CC_CAP_MODE_HI:`CC_CAP_MODE_LO] = cap_mode_r;
    end else if (sel_cap_buf) begin
      rdata[15:0] = buf_nempty ? buf_mem[rd_ptr_r] : 16'h0000;
    end else if (sel_cmp_ctrl) begin
      rdata[`CC_CMP_IDLE_BIT] = cmp_stop_r;
      rdata[`CC_CMP_FLT_BIT]  = cmp_flt_r;
      rdata[`CC_CMP_TSEL_BIT] = cmp_tsel_r;
      rdata[`CC_CMP_MODE_HI:`CC_CMP_MODE_LO] = cmp_mode_r;
    end else if (sel_cmp_pri) begin
      rdata[15:0] = cmp_pri_r;
    end else if (sel_cmp_sec) begin
      rdata[15:0] = cmp_sec_r;
    end
  end

  always @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      prdata_o      <= 32'h0000_0000;
      pready_o      <= 1'b0;
      pslverr_o     <= 1'b0;
      capture_irq_o <= 1'b0;
      wake_o        <= 1'b0;
    end else begin
      // One wait state: pready rises in the second access cycle
      pready_o  <= acc_start;
      pslverr_o <= acc_start & ~sel_any;
      prdata_o  <= (acc_start & ~pwrite_i) ? rdata : 32'h0000_0000;
      capture_irq_o <= (cap_ev & cap_cnt_hit) | cap_wake_ev;
      wake_o        <= low_power & (cap_ev | cap_wake_ev);
    end
  end

endmodule // timer_capture_compare_channel

`default_nettype wire

// ===== verif/cc_properties.sv
// Port checker for the capture/compare channel, bound to its top module.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module cc_properties (
  // Clock and reset
  input wire logic        ref_clk_i,
  input wire logic        rstn_i,
  // APB and power state
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic        cpu_idle_i,
  input wire logic        cpu_sleep_i,
  // Pins and events
  input wire logic        compare_output_pin_o,
  input wire logic        compare_output_oe_o,
  input wire logic        capture_irq_o,
  input wire logic        compare_irq_o,
  input wire logic        wake_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  ////////////////////////////////////////////////////////////////////////////
  AST_APB_WAIT: assert property (psel_i && !penable_i |-> ##2 pready_o)
    else $error("no ready two cycles after setup");
  AST_READY_ONE: assert property (pready_o |=> !pready_o)
    else $error("ready longer than one cycle");
  AST_ERR_READY: assert property (pslverr_o |-> pready_o && prdata_o == 32'h0)
    else $error("error without ready or with data");
  AST_CAP_IRQ_PULSE: assert property (capture_irq_o |=> !capture_irq_o)
    else $error("capture interrupt not a pulse");
  AST_WAKE_PULSE: assert property (wake_o |=> !wake_o)
    else $error("wake not a pulse");
  AST_WAKE_LOWPWR: assert property (wake_o |-> $past(cpu_idle_i) || $past(cpu_sleep_i))
    else $error("wake while running");
  AST_CMP_IRQ_OE: assert property (compare_irq_o |-> compare_output_oe_o)
    else $error("compare interrupt while disabled");
  AST_CMP_IRQ_PULSE: assert property (compare_irq_o |=> !compare_irq_o)
    else $error("compare interrupt not a pulse");
  AST_CMP_IRQ_EDGE: assert property (compare_irq_o |-> $changed(compare_output_pin_o) || !compare_output_pin_o)
    else $error("compare interrupt without pin edge");
  AST_RST_QUIET: assert property ($rose(rstn_i) |-> !compare_output_oe_o && !capture_irq_o && !wake_o)
    else $error("outputs active after reset");
endmodule // cc_properties
bind timer_capture_compare_channel cc_properties u_props (
  .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .psel_i(psel_i), .penable_i(penable_i),
  .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .cpu_idle_i(cpu_idle_i), .cpu_sleep_i(cpu_sleep_i),
  .compare_output_pin_o(compare_output_pin_o), .compare_output_oe_o(compare_output_oe_o),
  .capture_irq_o(capture_irq_o), .compare_irq_o(compare_irq_o), .wake_o(wake_o)
);
`default_nettype wire

// ===== verif/pin_partner.sv
// Far side of the channel: capture pin, fault pin and both time bases.
// Assumes the bench calls its tasks; pins move only after a clock edge.
`timescale 1ns/1ps
`default_nettype none
module pin_partner (
  // Clock
  input  wire logic        clk_i,
  // Pins and time bases
  output var  logic        cap_pin_o,
  output var  logic        flt_pin_o,
  output var  logic [15:0] t2_o,
  output var  logic [15:0] t3_o
);
  initial begin
    cap_pin_o = 1'b0;
    flt_pin_o = 1'b1;
    t2_o = 16'h0;
    t3_o = 16'h0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Timers settle before the pin moves and hold while the edge syncs
  task automatic cap_edge(input logic lvl, input logic [15:0] a, input logic [15:0] b);
    @(posedge clk_i);
    t2_o <= a;
    t3_o <= b;
    @(posedge clk_i);
    cap_pin_o <= lvl;
    repeat (10) @(posedge clk_i);
  endtask
  // Timer runs 0 to 15 only between control writes
  task automatic sweep();
    for (int t = 0; t < 16; t++) begin
      @(posedge clk_i);
      t2_o <= t[15:0];
    end
    repeat (4) @(posedge clk_i);
  endtask
  task automatic set_fault(input logic lvl);
    @(posedge clk_i);
    flt_pin_o <= lvl;
    repeat (10) @(posedge clk_i);
  endtask
endmodule // pin_partner
`default_nettype wire

// ===== verif/timer_capture_compare_channel_test.sv
// Self-checking bench: APB master, queue model of captures, compare table.
// Assumes the pin partner drives both pins and both time bases.
`timescale 1ns/1ps
`default_nettype none
module timer_capture_compare_channel_test;
  logic        clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        idle = 1'b0, sleep = 1'b0, ovf;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd, c;
  logic [15:0] t2, t3, a, b;
  logic [15:0] q[$];
  logic [2:0]  m;
  logic        pready, pslverr, er, cap_pin, flt_pin, pin, oe, cirq, mirq, wake;
  int          n_mismatch = 0, checks_done = 0, n_ci = 0, n_mi = 0, n_wk = 0, ncap, nrise;
  // Control word, edge pairs, power state (1 idle, 2 sleep); 0x84, 0x5 use one per irq
  int cc_ctrl[9] = '{32'h61, 32'hC2, 32'h23, 32'h84, 32'h5, 32'h6, 32'h2003, 32'h83, 32'h7};
  int cc_pairs[9] = '{2, 3, 4, 8, 16, 2, 2, 6, 2};
  int cc_pwr[9] = '{0, 0, 0, 0, 0, 0, 1, 1, 2};
  // Expect: bit0 pin after write, bit1 pin after sweep, bits 3:2 interrupts
  int cm_ctrl[9] = '{32'h1, 32'h2, 32'h3, 32'h4, 32'h5, 32'h6, 32'h9, 32'h2001, 32'h0};
  int cm_exp[9] = '{6, 5, 6, 4, 4, 1, 0, 0, 0};

  timer_capture_compare_channel dut_u (
    .ref_clk_i(clk), .rstn_i(rstn), .paddr_i(paddr), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .second_timer_count_i(t2), .third_timer_count_i(t3),
    .cpu_idle_i(idle), .cpu_sleep_i(sleep), .capture_input_pin_i(cap_pin),
    .compare_fault_input_i(flt_pin), .compare_output_pin_o(pin), .compare_output_oe_o(oe),
    .capture_irq_o(cirq), .compare_irq_o(mirq), .wake_o(wake));
  pin_partner partner (.clk_i(clk), .cap_pin_o(cap_pin), .flt_pin_o(flt_pin), .t2_o(t2), .t3_o(t3));
  ////////////////////////////////////////////////////////////////////////////
  initial forever #4 clk = ~clk;
  // Events are counted mid-cycle, where the registered pulses are settled
  always @(negedge clk) begin
    n_ci += (cirq === 1'b1);
    n_mi += (mirq === 1'b1);
    n_wk += (wake === 1'b1);
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic apb(input logic [11:0] ad, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    paddr <= ad;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    chk(n < 20, 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  initial begin
    repeat (25000) @(posedge clk);
    n_mismatch++;
    $display("MISMATCH t=%0t watchdog", $time);
    tally_and_finish();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h99D5));
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    for (int k = 0; k < 6; k++) begin
      apb(12'(4 * k), 1'b0, 32'h0);
      chk(rd, 32'h0);
      chk(er, k == 5);
    end
    $display("reset values done");
    for (int k = 0; k < 9; k++) begin
      c = cc_ctrl[k];
      m = c[2:0];
      apb(12'h000, 1'b1, 32'h0);
      apb(12'h000, 1'b1, c);
      idle <= cc_pwr[k] == 1;
      sleep <= cc_pwr[k] == 2;
      n_ci = 0;
      n_wk = 0;
      ncap = 0;
      nrise = 0;
      ovf = 1'b0;
      for (int i = 0; i < 2 * cc_pairs[k]; i++) begin
        a = 16'($urandom);
        b = 16'($urandom);
        partner.cap_edge(!i[0], a, b);
        nrise += !i[0];
        if (!(c[13] && idle) && (m == 1 || (m == 2 && i[0]) || (m == 3 && !i[0]) ||
            (m == 4 && !i[0] && nrise % 4 == 0) || (m == 5 && !i[0] && nrise % 16 == 0))) begin
          ncap++;
          if (q.size() < 4) q.push_back(c[7] ? a : b);
          else ovf = 1'b1;
        end
      end
      apb(12'h000, 1'b0, 32'h0);
      chk(rd[4], ovf);
      chk(rd[3], q.size() != 0);
      if (m == 7) chk(n_ci, cc_pairs[k]);
      else chk(n_ci, m == 1 ? ncap : ncap / (c[6:5] + 1));
      chk(n_wk, m == 7 ? cc_pairs[k] : (cc_pwr[k] != 0) * ncap);
      while (q.size() > 0) begin
        apb(12'h004, 1'b0, 32'h0);
        chk(rd, {16'h0, q.pop_front()});
      end
      $display("capture case %0d done", k);
    end
    sleep <= 1'b0;
    apb(12'h000, 1'b1, 32'h0);
    apb(12'h00C, 1'b1, 32'h5);
    apb(12'h010, 1'b1, 32'h9);
    apb(12'h00C, 1'b0, 32'h0);
    chk(rd, 32'h5);
    partner.cap_edge(1'b0, 16'h0, 16'hFFFF);
    for (int k = 0; k < 9; k++) begin
      @(posedge clk);
      idle <= cm_ctrl[k][13];
      n_mi = 0;
      apb(12'h008, 1'b1, cm_ctrl[k]);
      @(negedge clk);
      chk(oe, cm_ctrl[k][2:0] != 0);
      if (cm_ctrl[k][2:0] != 0) chk(pin, cm_exp[k][0]);
      partner.sweep();
      @(negedge clk);
      if (cm_ctrl[k][2:0] != 0) chk(pin, cm_exp[k][1]);
      chk(n_mi, cm_exp[k][3:2]);
      $display("compare case %0d done", k);
    end
    apb(12'h008, 1'b1, 32'h7);
    @(negedge clk);
    chk(pin, 1'b1);
    n_mi = 0;
    partner.set_fault(1'b0);
    partner.sweep();
    chk(pin, 1'b0);
    chk(n_mi, 1);
    apb(12'h008, 1'b0, 32'h0);
    chk(rd[4], 1'b1);
    partner.set_fault(1'b1);
    apb(12'h008, 1'b1, 32'h7);
    apb(12'h008, 1'b0, 32'h0);
    chk(rd[4], 1'b0);
    chk(pin, 1'b1);
    $display("fault case done");
    tally_and_finish();
  end
endmodule // timer_capture_compare_channel_test
`default_nettype wire
